// File: eitr_top.sv
// External interrupt and transfer-request unit, top level
`timescale 1ns/100ps
`include "eitr_map.svh"
module eitr_top
    import eitr_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    // Request pins
    input  wire logic                    ext_req_line_a,
    input  wire logic                    ext_req_line_b,
    input  wire logic                    ext_req_line_c,
    input  wire logic                    ext_req_line_d,
    input  wire logic                    can_rx,
    // Control
    input  wire logic [9:0]              detect_level_select_reg,
    input  wire logic [4:0]              ext_irq_enable_reg,
    input  wire logic [4:0]              cause_clear,
    input  wire logic                    transfer_service_enable,
    input  wire logic [`EITR_CNT_W-1:0]  xfer_count,
    input  wire logic                    xfer_done,
    input  wire logic                    irq_ack,
    // Status and requests
    output logic [4:0]                   ext_irq_cause_reg,
    output logic                         xfer_req,
    output logic                         irq_req,
    output logic [7:0]                   irq_vector,
    output logic                         wakeup
);
    // ****************************************
    // Input channels
    // ****************************************
    logic [4:0] pins;
    logic [4:0] pend;
    eitr_core_t st_reg, st_next;

    // ****************************************
    // Timing overview
    // ****************************************
    // Pin change seen at edge 0 of the machine clock
    // Edge 1: first sync flop holds the new level
    // Edge 2: second sync flop holds it; detector sees it
    // Edge 3: cause bit latches the detected condition
    // Edge 4: request or transfer pulse leaves the sequencer
    // Total: four edges from pin to request output
    //
    // Level modes re-set the cause every cycle the level holds
    // Software must clear the cause after moving the pin away,
    // otherwise a held level raises a fresh request at once
    //
    // Edge modes fire once per transition
    // Previous-sample flop starts at zero like idle pins,
    // so no false rising edge follows reset
    //
    // Transfer mode masks edge detection on every channel;
    // only the level modes can drive the transfer engine
    //
    // The enable mask acts after the cause flag:
    // a blocked input still records its cause for polling
    //
    // Bus receive line shares the path of the four request
    // lines; its masked cause doubles as the wakeup output
    //
    // Limitation: pulses shorter than one clock period may
    // be missed by the synchroniser; slow edges are safe

    assign pins = {can_rx, ext_req_line_d, ext_req_line_c, ext_req_line_b, ext_req_line_a};

    // One detector per input
    genvar g;
    generate
        for (g = 0; g < `EITR_NUM_IN; g++) begin : g_chan
            eitr_chan u_chan (
                .clk        (clk),
                .rst_b      (rst_b),
                .pin        (pins[g]),
                .det_sel    (detect_level_select_reg[2*g+1:2*g]),
                .level_only (transfer_service_enable),
                .cause_clr  (cause_clear[g]),
                .cause      (ext_irq_cause_reg[g])
            );
        end
    endgenerate

    assign pend = ext_irq_cause_reg & ext_irq_enable_reg;

    // ****************************************
    // Vector selection
    // ****************************************
    // Three vectors serve five inputs, so inputs share them
    // Lowest group wins when several causes are pending;
    // the handler then polls the cause bits to tell them apart
    //
    // Trade-off: fixed priority keeps the logic small but a
    // busy low group can delay a higher group indefinitely
    // if software never clears the low group's cause
    //
    // The vector is captured with the request and held
    // while the request stands, so it cannot change under
    // the handler even if new causes arrive meanwhile

    // Vector grouping: a,b -> first; c,d -> second; bus receive -> third
    function automatic logic [7:0] eitr_vec(input logic [4:0] p);
        if (p[1:0] != 2'h0) begin
            eitr_vec = `EITR_VEC_A;
        end else if (p[3:2] != 2'h0) begin
            eitr_vec = `EITR_VEC_B;
        end else begin
            eitr_vec = `EITR_VEC_C;
        end
    endfunction

    // ****************************************
    // Service sequencing
    // ****************************************
    // Idle: waits for any enabled pending cause
    //
    // Service off: the request goes straight to the handler
    // and stands until the processor acknowledges it
    //
    // Service on: each request issues a single transfer pulse
    // and then waits for the engine to report completion
    // The counter loads on the first transfer of a series
    // and counts down on each completion; the last
    // completion raises the handler request
    //
    // A count of zero is treated like one, so a series
    // always has at least one transfer before the branch
    //
    // Hazard: the engine is trusted to answer each pulse;
    // a missing completion leaves the sequencer waiting
    //
    // Between transfers the sequencer passes through idle,
    // so a cleared cause ends the series early without a
    // handler request, as the count is kept for the next one

    // Transfer mode counts completed transfers before the handler branch
    always_comb begin
        st_next            = st_reg;
        st_next.xfer_pulse = 1'b0;
        unique case (st_reg.state)
            EITR_IDLE: begin
                if (pend != `EITR_NONE_PEND) begin
                    st_next.vector = eitr_vec(pend);
                    if (transfer_service_enable) begin
                        st_next.state      = EITR_XFER;
                        st_next.xfer_pulse = 1'b1;
                        if (st_reg.xfer_left == '0) begin
                            st_next.xfer_left = xfer_count;
                        end
                    end else begin
                        st_next.state = EITR_BRANCH;
                        st_next.irq   = 1'b1;
                    end
                end
            end
            EITR_XFER: begin
                // Wait for the transfer engine before taking the next request
                if (xfer_done) begin
                    if (st_reg.xfer_left <= `EITR_CNT_LAST) begin
                        st_next.xfer_left = '0;
                        st_next.state     = EITR_BRANCH;
                        st_next.irq       = 1'b1;
                    end else begin
                        st_next.xfer_left = st_reg.xfer_left - `EITR_CNT_LAST;
                        st_next.state     = EITR_IDLE;
                    end
                end
            end
            EITR_BRANCH: begin
                if (irq_ack) begin
                    st_next.irq   = 1'b0;
                    st_next.state = EITR_IDLE;
                end
            end
            default: st_next.state = EITR_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '{state: EITR_IDLE, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Request, pulse and vector come straight from flops,
    // so the interrupt system sees glitch-free levels
    //
    // Wakeup is combinational from the masked cause so it
    // can reach the clock control without an extra cycle;
    // its inputs are flops, so it does not glitch either
    //
    // The transfer pulse is one cycle wide; the engine must
    // capture it on the edge that follows it

    assign xfer_req   = st_reg.xfer_pulse;
    assign irq_req    = st_reg.irq;
    assign irq_vector = st_reg.vector;
    assign wakeup     = pend[`EITR_IDX_RX];
endmodule // eitr_top

// File: eitr_map.svh
// Constants for the external interrupt and transfer-request unit
`ifndef EITR_MAP_SVH
`define EITR_MAP_SVH
`define EITR_NUM_IN        5
`define EITR_IDX_RX        4
`define EITR_DET_LOW       2'h0
`define EITR_DET_HIGH      2'h1
`define EITR_DET_RISE      2'h2
`define EITR_DET_FALL      2'h3
`define EITR_VEC_A         8'h0F
`define EITR_VEC_B         8'h18
`define EITR_VEC_C         8'h1B
`define EITR_CNT_W         8
`define EITR_CNT_LAST      8'h01
`define EITR_NONE_PEND     5'h00
`endif

// File: eitr_pkg.sv
// Types for the external interrupt and transfer-request unit
`include "eitr_map.svh"
package eitr_pkg;
    typedef enum logic [1:0] {EITR_IDLE, EITR_XFER, EITR_BRANCH} eitr_state_t;
    typedef struct packed {
        eitr_state_t                state;
        logic [`EITR_CNT_W-1:0]     xfer_left;
        logic                       xfer_pulse;
        logic                       irq;
        logic [7:0]                 vector;
    } eitr_core_t;
endpackage

// File: eitr_chan.sv
// One request channel: synchroniser, detector and cause flag
`timescale 1ns/100ps
`include "eitr_map.svh"
module eitr_chan
    import eitr_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Pin and control
    input  wire logic       pin,
    input  wire logic [1:0] det_sel,
    input  wire logic       level_only,
    input  wire logic       cause_clr,
    // Status
    output logic            cause
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        logic cause;
    } eitr_chan_t;
    eitr_chan_t st_reg, st_next;
    logic       hit;

    // Detection and next state; edges masked in transfer mode
    // A new hit beats a clear so no event is lost
    always_comb begin
        st_next       = st_reg;
        hit           = 1'b0;
        unique case (det_sel)
            `EITR_DET_LOW:  hit = !st_reg.s2;
            `EITR_DET_HIGH: hit = st_reg.s2;
            `EITR_DET_RISE: hit = !level_only && st_reg.s2 && !st_reg.prev;
            `EITR_DET_FALL: hit = !level_only && !st_reg.s2 && st_reg.prev;
        endcase
        st_next.s1    = pin;
        st_next.s2    = st_reg.s1;
        st_next.prev  = st_reg.s2;
        st_next.cause = hit | (st_reg.cause & !cause_clr);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign cause = st_reg.cause;
endmodule // eitr_chan

// File: eitr_checker.sv
// Assertion checker for the external request unit
`timescale 1ns/100ps
module eitr_checker (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       ext_req_line_a,
    input wire logic [9:0] detect_level_select_reg,
    input wire logic [4:0] ext_irq_enable_reg,
    input wire logic       transfer_service_enable,
    input wire logic       xfer_done,
    input wire logic       irq_ack,
    input wire logic [4:0] ext_irq_cause_reg,
    input wire logic       xfer_req,
    input wire logic       irq_req,
    input wire logic [7:0] irq_vector,
    input wire logic       wakeup
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    wake_mirror_a: assert property (wakeup == (ext_irq_cause_reg[4] & ext_irq_enable_reg[4]))
        else $error("wakeup wrong");
    // Three synced samples of a held level must latch
    level_latch_a: assert property ((ext_req_line_a && detect_level_select_reg[1:0] == 2'h1)[*3]
        |=> ext_irq_cause_reg[0]) else $error("cause not set");
    mask_block_a: assert property ($rose(irq_req)
        |-> $past(|(ext_irq_cause_reg & ext_irq_enable_reg))) else $error("masked request");
    req_hold_a: assert property (irq_req && !irq_ack |=> irq_req) else $error("irq dropped");
    ack_drop_a: assert property (irq_req && irq_ack |=> !irq_req) else $error("irq stuck");
    xfer_pulse_a: assert property (xfer_req |=> !xfer_req) else $error("long xfer");
    xfer_gate_a: assert property ($rose(irq_req) && transfer_service_enable
        |-> $past(xfer_done)) else $error("early branch");
    vector_map_a: assert property ($rose(irq_req)
        |-> irq_vector inside {8'h0F, 8'h18, 8'h1B}) else $error("bad vector");
    cover property ($rose(irq_req) && !transfer_service_enable);
    cover property (xfer_req);
    cover property (wakeup);
endmodule // eitr_checker
bind eitr_top eitr_checker chk (.*);

// File: eitr_partner.sv
// Peripheral model: request pin drivers and a transfer engine
`timescale 1ns/100ps
module eitr_partner (
    input  wire logic       clk,
    input  wire logic       xfer_req,
    input  wire logic [3:0] lag,
    output logic [4:0]      pins,
    output logic            xfer_done
);
    initial pins = 5'h00;
    initial xfer_done = 1'b0;
    // Pins move just after an edge and then hold
    task automatic put(input int i, input logic v);
        @(posedge clk) pins[i] <= v;
    endtask
    // One done pulse per transfer; lag models a slow engine
    always @(posedge clk) if (xfer_req) begin
        repeat (lag) @(posedge clk);
        xfer_done <= 1'b1;
        @(posedge clk) xfer_done <= 1'b0;
    end
endmodule // eitr_partner

// File: eitr_test.sv
// Self-checking bench for the external request unit
`timescale 1ns/100ps
module eitr_test;
    logic       clk = 0, rst_b = 0, svc = 0, ack = 0, done, xreq, irq, wake;
    logic [9:0] sel = 10'h2AA;
    logic [4:0] en = 5'h00, clr = 5'h00, pins, cause;
    logic [7:0] vec;
    int         err_count = 0, samples_checked = 0, nx = 0;
    eitr_top dut (.clk(clk), .rst_b(rst_b), .ext_req_line_a(pins[0]), .ext_req_line_b(pins[1]),
        .ext_req_line_c(pins[2]), .ext_req_line_d(pins[3]), .can_rx(pins[4]),
        .detect_level_select_reg(sel), .ext_irq_enable_reg(en), .cause_clear(clr),
        .transfer_service_enable(svc), .xfer_count(8'h02), .xfer_done(done), .irq_ack(ack),
        .ext_irq_cause_reg(cause), .xfer_req(xreq), .irq_req(irq), .irq_vector(vec), .wakeup(wake));
    eitr_partner p (.clk(clk), .xfer_req(xreq), .lag(4'h3), .pins(pins), .xfer_done(done));
    initial forever #5 clk = ~clk;
    always @(posedge clk) if (xreq === 1'b1) nx++;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Pick a mode, move the pin, wait out sync, latch and request
    task automatic hit(input int i, input logic [1:0] m, input logic v);
        @(posedge clk) sel[2*i+:2] <= m;
        p.put(i, v);
        repeat (5) @(posedge clk);
        #1;
    endtask
    // Clear before ack, otherwise a held cause fires again
    task automatic rel(input int i);
        @(posedge clk) sel[2*i+:2] <= 2'h2;
        clr[i] <= 1'b1;
        repeat (4) @(posedge clk);
        clr[i] <= 1'b0;
        ack <= 1'b1;
        @(posedge clk) ack <= 1'b0;
        #1 chk(irq, 1'b0);
    endtask
    task automatic t_direct;
        @(posedge clk) en <= 5'h05;
        hit(0, 2'h1, 1'b1);
        chk(irq, 1'b1);
        chk(vec, 8'h0F);
        rel(0);
    endtask
    task automatic t_edges;
        hit(2, 2'h2, 1'b1);
        chk(vec, 8'h18);
        rel(2);
        hit(2, 2'h3, 1'b0);
        chk(irq, 1'b1);
        rel(2);
    endtask
    task automatic t_rx_mask;
        @(posedge clk) en <= 5'h10;
        hit(4, 2'h0, 1'b0);
        chk(wake, 1'b1);
        chk(vec, 8'h1B);
        rel(4);
        hit(1, 2'h1, 1'b1);
        chk(cause[1], 1'b1);
        chk(irq, 1'b0);
        rel(1);
    endtask
    task automatic t_xfer;
        @(posedge clk) svc <= 1'b1;
        en <= 5'h18;
        hit(4, 2'h2, 1'b1);
        chk(nx, 8'h00);
        hit(3, 2'h1, 1'b1);
        for (int k = 0; k < 60 && irq !== 1'b1; k++) @(posedge clk);
        #1 chk(nx, 8'h02);
        rel(3);
    endtask
    task automatic finish_test;
        $display("Comparisons %0d, errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #20us;
        err_count++;
        finish_test();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        t_direct();
        t_edges();
        t_rx_mask();
        t_xfer();
        finish_test();
    end
endmodule // eitr_test
